//--- verilog/sao_map.vh
/*
 Holds the constants of the step actuator output block: register offsets, field positions,
 reset values and timing counts, with the contract of the block in its head comment.
 Assumes it is included by its bare name from the design files of the block.
*/
// Contract
// - Motor moved only by an upscale relay and a downscale relay, no position feedback.
// - Estimate set exactly to 0 or 100 percent when motor driven fully to a stop.
// - In step control the position readout shows whole percent, no fraction.
// - Estimate scales with configured full travel time, which must be set before control works.
// - Slidewire reading shown to one decimal for display only, never used by control.
// - After power-up tests complete, the output goes to the configured failsafe value.
// - For non-step outputs the failsafe value is accepted only within 0 to 100 percent.
// - For step output failsafe 100 drives motor open; failsafe 0 drives no relay, as the estimate resets to 0.
// - Latching failsafe forces manual mode and sets output to failsafe value.
// - Non-latching failsafe sets output to failsafe value, mode left unchanged.
`ifndef SAO_MAP_VH
`define SAO_MAP_VH

// =====================================================================
// Register offsets
`define SAO_REG_CTRL 4'h0
`define SAO_REG_TRAVEL 4'h1
`define SAO_REG_FAILSAFE 4'h2
`define SAO_REG_DEMAND 4'h3
`define SAO_REG_STATUS 4'h4
`define SAO_REG_READOUT 4'h5
`define SAO_REG_SLIDEWIRE 4'h6

// =====================================================================
// Control register fields
`define SAO_CTRL_STEP_BIT 0
`define SAO_CTRL_LATCH_BIT 1
`define SAO_CTRL_MANUAL_BIT 2
`define SAO_CTRL_SLIDE_BIT 3
`define SAO_CTRL_RESET 4'h1

// =====================================================================
// Reset values and ranges
`define SAO_TRAVEL_RESET 16'h0000
`define SAO_FAILSAFE_RESET 8'h00
`define SAO_PCT_MAX 8'h64

// =====================================================================
// Timing: one travel-time unit is 0.1 s.
`define SAO_TICK_US 100000
`define SAO_CLK_MHZ 100
`define SAO_TICK_CYCLES (`SAO_TICK_US * `SAO_CLK_MHZ)
`define SAO_SELFTEST_US 1000
`define SAO_SELFTEST_CYCLES (`SAO_SELFTEST_US * `SAO_CLK_MHZ)

`endif

//--- verilog/sao_position.v
/*
 Position estimator of the step actuator output block.
 Assumes a single clock and a one-cycle tick enable at a rate of 1000 per travel-time unit.
*/
`timescale 1ns/1ps
`include "sao_map.vh"

module sao_position (
   input wire clk, // System clock.
   input wire rst, // Synchronous reset, active high.
   input wire tick, // Sub-tick enable, 1000 per travel unit.
   input wire drive_up, // Upscale relay energized.
   input wire drive_down, // Downscale relay energized.
   input wire [15:0] travel, // Full travel time in 0.1 s units.
   output reg [17:0] pos_milli // Estimate in thousandths of a percent, 0 to 100000.
);
   localparam [17:0] POS_FULL = 18'h186a0; // 100 percent expressed as 100000 counts.

   reg [15:0] acc;
   reg [17:0] next_pos;

   // Each step adds 100 counts, so 1000 steps make a full stroke; a step takes travel sub-ticks,
   // so we accumulate sub-ticks and step 100 counts per travel sub-ticks.
   always @* begin
      next_pos = pos_milli;
      if (tick && travel != 16'h0000 && acc + 16'h0001 >= travel) begin
         if (drive_up && pos_milli < POS_FULL)
            next_pos = (pos_milli + 18'h00064 > POS_FULL) ? POS_FULL : pos_milli + 18'h00064;
         else if (drive_down && pos_milli != 18'h00000)
            next_pos = (pos_milli < 18'h00064) ? 18'h00000 : pos_milli - 18'h00064;
      end
   end

   // The accumulator only runs while a relay is on, so idle time never moves the estimate.
   always @(posedge clk) begin
      if (rst) begin
         acc <= 16'h0000;
         pos_milli <= 18'h00000;
      end else begin
         pos_milli <= next_pos;
         if (tick && (drive_up || drive_down)) begin
            if (acc + 16'h0001 >= travel)
               acc <= 16'h0000;
            else
               acc <= acc + 16'h0001;
         end
      end
   end
endmodule // sao_position

//--- verilog/sao_step_output.v
/*
 Top of the step actuator output block: register port, failsafe start-up, relay drive and
 position readout.
 Assumes one 100 MHz clock, a synchronous reset at power-up, and a motor with end stops.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "sao_map.vh"

module sao_step_output #(
   parameter TICK_CYCLES = `SAO_TICK_CYCLES / 1000, // Cycles per sub-tick of travel time.
   parameter SELFTEST_CYCLES = `SAO_SELFTEST_CYCLES // Length of the power-up test.
) (
   input wire REF_CLK, // System clock, 100 MHz.
   input wire SYS_RST, // Synchronous reset, active high.
   input wire [3:0] ADDR, // Register address.
   input wire [15:0] WDATA, // Write data.
   input wire WR, // Write strobe.
   input wire RD, // Read strobe.
   output reg [15:0] RDATA, // Read data, one cycle after the strobe.
   input wire [9:0] SLIDEWIRE_IN, // Third analog input, tenths of a percent.
   output reg RELAY_UP, // Upscale relay drive.
   output reg RELAY_DOWN, // Downscale relay drive.
   output reg MANUAL_MODE, // Controller in manual mode.
   output reg READY // Power-up tests done, failsafe applied.
);
   // =====================================================================
   // Registers and state
   reg [3:0] ctrl;
   reg [15:0] travel;
   reg [7:0] failsafe;
   reg [7:0] demand;
   reg [7:0] target;
   reg [31:0] test_cnt;
   reg [31:0] tick_cnt;
   reg tick;
   reg ready_q;
   reg at_stop_lo;
   reg at_stop_hi;
   reg [1:0] state;
   reg [1:0] next_state;
   wire [17:0] pos_milli;
   wire step_mode;
   wire [7:0] pct;

   localparam [1:0] ST_TEST = 2'h0;
   localparam [1:0] ST_FAILSAFE = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // Rounds the estimate (in 1/1000 percent) to whole percent, capped at 100.
   function [7:0] round_pct;
      input [17:0] milli;
      reg [17:0] q;
      begin
         q = (milli + 18'h001f4) / 18'h003e8;
         round_pct = (q > 18'h00064) ? `SAO_PCT_MAX : q[7:0];
      end
   endfunction

   // Clamps a written percentage to the legal range.
   function [7:0] clamp_pct;
      input [15:0] v;
      begin
         clamp_pct = (v > 16'h0064) ? `SAO_PCT_MAX : v[7:0];
      end
   endfunction

   assign step_mode = ctrl[`SAO_CTRL_STEP_BIT];
   assign pct = round_pct(pos_milli);

   // =====================================================================
   // Sub-tick divider for relay on-time integration.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b0;
      end else if (tick_cnt >= TICK_CYCLES - 1) begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end

   // =====================================================================
   // Start-up sequence: test, then apply the failsafe value once.
   always @* begin
      next_state = state;
      case (state)
         ST_TEST: if (test_cnt >= SELFTEST_CYCLES - 1) next_state = ST_FAILSAFE;
         ST_FAILSAFE: next_state = ST_RUN;
         ST_RUN: next_state = ST_RUN;
         default: next_state = ST_TEST;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         state <= ST_TEST;
         test_cnt <= 32'h00000000;
      end else begin
         state <= next_state;
         if (state == ST_TEST)
            test_cnt <= test_cnt + 32'h00000001;
      end
   end

   // =====================================================================
   // Register writes; the failsafe step overrides the demand and, if latching, the mode.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl <= `SAO_CTRL_RESET;
         travel <= `SAO_TRAVEL_RESET;
         failsafe <= `SAO_FAILSAFE_RESET;
         demand <= 8'h00;
         MANUAL_MODE <= 1'b0;
         READY <= 1'b0;
      end else begin
         if (WR) begin
            case (ADDR)
               `SAO_REG_CTRL: begin
                  ctrl <= WDATA[3:0];
                  MANUAL_MODE <= WDATA[`SAO_CTRL_MANUAL_BIT];
               end
               `SAO_REG_TRAVEL: travel <= WDATA;
               `SAO_REG_FAILSAFE: failsafe <= clamp_pct(WDATA);
               `SAO_REG_DEMAND: demand <= clamp_pct(WDATA);
               default: ;
            endcase
         end
         if (state == ST_FAILSAFE) begin
            demand <= failsafe;
            READY <= 1'b1;
            if (ctrl[`SAO_CTRL_LATCH_BIT])
               MANUAL_MODE <= 1'b1;
            // Non-latching leaves the mode as it was.
         end
      end
   end

   // =====================================================================
   // Relay drive: move toward the target; a target of 0 or 100 keeps driving until the estimate reaches that end.
   // The drive waits one cycle after READY so the stale pre-failsafe target cannot pulse a relay.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         RELAY_UP <= 1'b0;
         RELAY_DOWN <= 1'b0;
         target <= 8'h00;
         ready_q <= 1'b0;
      end else begin
         target <= demand;
         ready_q <= READY;
         if (!READY || !ready_q || !step_mode || travel == 16'h0000) begin
            RELAY_UP <= 1'b0;
            RELAY_DOWN <= 1'b0;
         end else if (target == `SAO_PCT_MAX || target > pct) begin
            RELAY_UP <= !at_stop_hi;
            RELAY_DOWN <= 1'b0;
         end else if (target == 8'h00 || target < pct) begin
            RELAY_UP <= 1'b0;
            RELAY_DOWN <= !at_stop_lo;
         end else begin
            RELAY_UP <= 1'b0;
            RELAY_DOWN <= 1'b0;
         end
      end
   end

   // The estimate sitting at an end, the low end only once READY, is taken as the motor on its stop.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         at_stop_lo <= 1'b0;
         at_stop_hi <= 1'b0;
      end else begin
         at_stop_hi <= (pos_milli == 18'h186a0);
         at_stop_lo <= (pos_milli == 18'h00000) && READY;
      end
   end

   // Estimator clamps at the exact end values, so each stop re-zeroes the estimate.
   sao_position u_pos (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .tick(tick),
      .drive_up(RELAY_UP),
      .drive_down(RELAY_DOWN),
      .travel(travel),
      .pos_milli(pos_milli)
   );

   // =====================================================================
   // Register reads; the slidewire is shown only here and feeds nothing else.
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         case (ADDR)
            `SAO_REG_CTRL: RDATA <= {12'h000, ctrl[3], MANUAL_MODE, ctrl[1:0]};
            `SAO_REG_TRAVEL: RDATA <= travel;
            `SAO_REG_FAILSAFE: RDATA <= {8'h00, failsafe};
            `SAO_REG_DEMAND: RDATA <= {8'h00, demand};
            `SAO_REG_STATUS: RDATA <= {12'h000, READY, at_stop_hi, RELAY_DOWN, RELAY_UP};
            `SAO_REG_READOUT: RDATA <= {8'h00, pct};
            `SAO_REG_SLIDEWIRE: RDATA <= ctrl[`SAO_CTRL_SLIDE_BIT] ?
                                         {6'h00, SLIDEWIRE_IN} : 16'h0000;
            default: RDATA <= 16'h0000;
         endcase
      end else begin
         RDATA <= 16'h0000;
      end
   end
endmodule // sao_step_output

//--- tb/sao_motor.sv
/* Behavioural actuator motor with two end stops, moved by an upscale and a downscale relay.
   Assumes relay drives synchronous to the clock; the motor reports nothing back. */
`timescale 1ns/1ps
module sao_motor #(
   parameter STROKE = 1900, // Cycles for a full stroke, a little faster than the estimate.
   parameter START = 950 // Shaft position at power-up.
) (
   input wire clk, // Clock.
   input wire up, // Upscale relay.
   input wire down, // Downscale relay.
   output wire at_open, // Upper stop reached.
   output wire at_closed // Lower stop reached.
);
   integer pos = START;
   // =====================================================================
   // The shaft stops hard at each end, which is why overdriving re-zeroes the estimate.
   always @(posedge clk) begin
      if (up && !down && pos < STROKE)
         pos <= pos + 1;
      else if (down && !up && pos > 0)
         pos <= pos - 1;
   end
   assign at_open = (pos == STROKE);
   assign at_closed = (pos == 0);
endmodule // sao_motor

//--- tb/sao_checker.sv
/* Port checker of the step actuator output block.
   Assumes it is bound to sao_step_output and sees one clock domain. */
`timescale 1ns/1ps
module sao_checker #(
   parameter SELFTEST_CYCLES = 4 // Power-up test length.
) (
   input wire REF_CLK, // Clock.
   input wire SYS_RST, // Reset.
   input wire [3:0] ADDR, // Address.
   input wire WR, // Write strobe.
   input wire RD, // Read strobe.
   input wire [15:0] RDATA, // Read data.
   input wire RELAY_UP, // Upscale relay.
   input wire RELAY_DOWN, // Downscale relay.
   input wire MANUAL_MODE, // Manual mode.
   input wire READY // Start-up done.
);
   reg [15:0] cnt;
   // =====================================================================
   // Cycles since reset release; saturates so a long run cannot wrap.
   always @(posedge REF_CLK) begin
      if (SYS_RST)
         cnt <= 16'h0000;
      else if (cnt != 16'hffff)
         cnt <= cnt + 16'h0001;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_bad_read;
      RD && ADDR > 4'h6;
   endsequence
   a_relay_excl: assert property (!(RELAY_UP && RELAY_DOWN))
      else $error("both relays on");
   a_reset_clear: assert property (disable iff (1'b0) SYS_RST |=> !RELAY_UP && !READY)
      else $error("outputs not cleared by reset");
   a_ready_sticky: assert property (READY |=> READY)
      else $error("ready dropped");
   a_drive_ready: assert property (!READY |-> !RELAY_UP && !RELAY_DOWN)
      else $error("relay driven during power-up test");
   a_ready_early: assert property (cnt < SELFTEST_CYCLES |-> !READY)
      else $error("ready too early");
   a_ready_late: assert property (cnt > SELFTEST_CYCLES + 2 |-> READY)
      else $error("ready too late");
   a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data without read");
   a_read_unmapped: assert property (s_bad_read |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_mode_hold: assert property (!WR && READY && $past(READY) |=> $stable(MANUAL_MODE))
      else $error("mode changed without write");
endmodule // sao_checker
bind sao_step_output sao_checker #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
   .RELAY_UP(RELAY_UP), .RELAY_DOWN(RELAY_DOWN), .MANUAL_MODE(MANUAL_MODE), .READY(READY));

//--- tb/tb.sv
/* Self-checking bench of the step actuator output block with a motor model.
   Assumes short sub-tick and power-up test parameters so a full stroke takes 2000 cycles. */
`timescale 1ns/1ps
`include "sao_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t mismatch %h vs %h", $time, a, b); end end
module tb;
   reg REF_CLK = 1'b0;
   reg SYS_RST = 1'b1;
   reg [3:0] ADDR = 4'h0;
   reg [15:0] WDATA = 16'h0000;
   reg WR = 1'b0;
   reg RD = 1'b0;
   reg [9:0] SLIDEWIRE_IN = 10'h219;
   wire [15:0] RDATA;
   wire RELAY_UP, RELAY_DOWN, MANUAL_MODE, READY, at_open, at_closed;
   integer failures = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   integer n;
   reg [15:0] d;
   always #5 REF_CLK = ~REF_CLK;
   sao_step_output #(.TICK_CYCLES(2), .SELFTEST_CYCLES(16)) u_dut (.REF_CLK(REF_CLK),
      .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SLIDEWIRE_IN(SLIDEWIRE_IN), .RELAY_UP(RELAY_UP), .RELAY_DOWN(RELAY_DOWN),
      .MANUAL_MODE(MANUAL_MODE), .READY(READY));
   sao_motor u_motor (.clk(REF_CLK), .up(RELAY_UP), .down(RELAY_DOWN), .at_open(at_open),
      .at_closed(at_closed));
   // =====================================================================
   // Bus cycles: one-cycle strobes, read data taken in the cycle after the strobe.
   task wr(input [3:0] a, input [15:0] v);
      @(posedge REF_CLK); ADDR <= a; WDATA <= v; WR <= 1'b1;
      @(posedge REF_CLK); WR <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge REF_CLK); ADDR <= a; RD <= 1'b1;
      @(posedge REF_CLK); RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task do_reset;
      @(posedge REF_CLK);
      SYS_RST <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      #1 `CHK({RELAY_UP, RELAY_DOWN, MANUAL_MODE, READY}, 4'h0)
   endtask
   task wait_ready;
      n = 0;
      while (READY !== 1'b1 && n < 100) begin @(posedge REF_CLK); n++; end
      #1 `CHK(READY, 1'b1)
   endtask
   // Bounded wait for both relays to drop; n holds the cycles spent.
   task wait_idle;
      n = 0;
      while ((RELAY_UP | RELAY_DOWN) !== 1'b0 && n < 3000) begin @(posedge REF_CLK); n++; end
      #1;
   endtask
   // =====================================================================
   // Reset values, refused reads, zero travel time and the display-only slidewire.
   task t_defaults;
      do_reset;
      rd(`SAO_REG_CTRL); `CHK(d, 16'h0001)
      rd(`SAO_REG_TRAVEL); `CHK(d, 16'h0000)
      rd(`SAO_REG_FAILSAFE); `CHK(d, 16'h0000)
      rd(4'hf); `CHK(d, 16'h0000)
      rd(`SAO_REG_SLIDEWIRE); `CHK(d, 16'h0000)
      wait_ready;
      `CHK(MANUAL_MODE, 1'b0)
      wr(`SAO_REG_DEMAND, 16'h0064);
      repeat (6) @(posedge REF_CLK);
      #1 `CHK({RELAY_UP, RELAY_DOWN}, 2'b00)
      wr(`SAO_REG_CTRL, 16'h0009);
      rd(`SAO_REG_SLIDEWIRE); `CHK(d, 16'h0219)
      rd(`SAO_REG_READOUT); `CHK(d, 16'h0000)
      $display("test defaults done");
   endtask
   // Latching failsafe at 100 percent drives the motor open and forces manual.
   task t_latch;
      do_reset;
      wr(`SAO_REG_CTRL, 16'h0003);
      wr(`SAO_REG_TRAVEL, 16'h0001);
      wr(`SAO_REG_FAILSAFE, 16'h0064);
      wait_ready;
      `CHK(MANUAL_MODE, 1'b1)
      repeat (4) @(posedge REF_CLK);
      #1 `CHK(RELAY_UP, 1'b1)
      wait_idle;
      rd(`SAO_REG_READOUT); `CHK(d, 16'h0064)
      `CHK(at_open, 1'b1)
      $display("test latch done");
   endtask
   // Half stroke down takes half the travel time; full close re-zeroes at the stop.
   task t_move;
      wr(`SAO_REG_DEMAND, 16'h0032);
      repeat (4) @(posedge REF_CLK);
      #1 `CHK(RELAY_DOWN, 1'b1)
      wait_idle;
      `CHK(n >= 985 && n <= 1005, 1'b1)
      rd(`SAO_REG_READOUT); `CHK(d, 16'h0032)
      wr(`SAO_REG_FAILSAFE, 16'h00c8);
      rd(`SAO_REG_FAILSAFE); `CHK(d, 16'h0064)
      wr(`SAO_REG_DEMAND, 16'h0000);
      repeat (4) @(posedge REF_CLK);
      wait_idle;
      rd(`SAO_REG_READOUT); `CHK(d, 16'h0000)
      `CHK(at_closed, 1'b1)
      $display("test move done");
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // The whole run needs under 8000 cycles; the ceiling leaves ample margin.
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test;
      end
   end
   initial begin
      t_defaults;
      t_latch;
      t_move;
      end_of_test;
   end
endmodule // tb
